// File: common/pft_pkg.sv
// Constants, types and helper functions of the port fault timers.
// Assumes a 50 MHz clock and a 1 ms timer tick.
package pft_pkg;
  localparam int NCH        = 4;
  localparam int CLK_HZ     = 50_000_000;
  localparam int TICK_US    = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int UP_RATIO   = 16;
  localparam int LIM_W      = 11;
  localparam int COOL_W     = 10;
  localparam int INR_W      = 8;
  localparam int COOL_MS    = 1000;
  localparam logic [COOL_W-1:0] COOL_TICKS =
    COOL_W'(COOL_MS * 1000 / TICK_US);
  localparam int LIM_NOM_MS = 60;
  localparam int LIM_MS_0   = 58;
  localparam int LIM_MS_1   = 15;
  localparam int LIM_MS_2   = 10;
  localparam int LIM_MS_3   = 6;
  localparam int INR_MS_0   = 60;
  localparam int INR_MS_1   = 30;
  localparam int INR_MS_2   = 120;
  localparam int INR_MS_3   = 240;
  localparam logic [LIM_W-1:0] UP_STEP   = 11'h010;
  localparam logic [LIM_W-1:0] DOWN_STEP = 11'h001;
  localparam int LIM_SEL_LSB = 6;
  localparam int INR_SEL_LSB = 4;
  localparam int OSS_SEL_LSB = 4;
  localparam int TIMING_RST  = 0;
  localparam logic [3:0] ADDR_TIMING   = 4'h0;
  localparam logic [3:0] ADDR_FOLDBACK = 4'h1;
  localparam logic [3:0] ADDR_MODE     = 4'h2;
  localparam logic [3:0] ADDR_DETCLS   = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h7;

  typedef enum logic [1:0] {MODE_OFF, MODE_MANUAL, MODE_SEMIAUTO,
                            MODE_AUTO} pft_mode_e;

  function automatic logic [LIM_W-1:0] pft_lim_timeout(
    input logic fb, input logic [1:0] sel);
    int ms;
    ms = LIM_NOM_MS;
    if (fb)
    begin
      case (sel)
        2'h0: ms = LIM_MS_0;
        2'h1: ms = LIM_MS_1;
        2'h2: ms = LIM_MS_2;
        default: ms = LIM_MS_3;
      endcase
    end
    return LIM_W'(ms * UP_RATIO * 1000 / TICK_US);
  endfunction : pft_lim_timeout

  function automatic logic [INR_W-1:0] pft_inr_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: return INR_W'(INR_MS_0 * 1000 / TICK_US);
      2'h1: return INR_W'(INR_MS_1 * 1000 / TICK_US);
      2'h2: return INR_W'(INR_MS_2 * 1000 / TICK_US);
      default: return INR_W'(INR_MS_3 * 1000 / TICK_US);
    endcase
  endfunction : pft_inr_ticks
endpackage : pft_pkg

// File: common/pft_ch_if.sv
// Per-channel signals between the fault timer top and its timers.
// Assumes one clock shared by all three modules.
`timescale 1ns/1ps
interface pft_ch_if;
  import pft_pkg::*;
  logic             ce;
  logic             tick;
  logic             limiting;
  logic             armed;
  logic             clear;
  logic             restart;
  logic [LIM_W-1:0] limit_to;
  logic             limit_fault;
  logic             start;
  logic             cancel;
  logic             cool_active;
  logic             cool_done;
  modport lim (input ce, tick, limiting, armed, clear, restart, limit_to,
               output limit_fault);
  modport cool (input ce, tick, start, cancel,
                output cool_active, cool_done);
endinterface : pft_ch_if

// File: rtl/pft_limit_timer.sv
// Current-limit fault counter of one channel.
// Assumes the tick pulse and all controls come from the same clock.
`timescale 1ns/1ps
module pft_limit_timer
  import pft_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  pft_ch_if.lim    ch
);
  typedef struct packed {
    logic [LIM_W-1:0] acc;
    logic             fault;
  } pft_lim_s;
  pft_lim_s s_r;
  pft_lim_s s_nxt;
  logic [LIM_W:0] up_sum;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.fault = 1'b0;
    up_sum      = {1'b0, s_r.acc} + {1'b0, UP_STEP};
    if (ch.clear || ch.restart)
      s_nxt.acc = '0;
    else if (ch.tick && ch.armed && ch.limiting)
    begin
      if (up_sum >= {1'b0, ch.limit_to})
      begin
        s_nxt.acc   = '0;
        s_nxt.fault = 1'b1;
      end
      else
        s_nxt.acc = up_sum[LIM_W-1:0];
    end
    else if (ch.tick && !ch.limiting)
      s_nxt.acc = (s_r.acc >= DOWN_STEP) ? s_r.acc - DOWN_STEP
                                         : '0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else if (ch.ce)
      s_r <= s_nxt;
  end

  assign ch.limit_fault = s_r.fault;

  AST_LIM_UP_ARMED: assert property (@(posedge clk) disable iff (!reset_n)
    ch.ce && !ch.armed |=> s_r.acc <= $past(s_r.acc))
    else $error("Limit counter rose while not armed.");
  AST_LIM_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
    ch.ce && ch.tick && !ch.limiting && !ch.clear && !ch.restart
    && s_r.acc != '0 |=> s_r.acc == $past(s_r.acc) - DOWN_STEP)
    else $error("Limit counter did not step down by one.");
  AST_LIM_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    ch.ce && (ch.clear || ch.restart) |=> s_r.acc == '0)
    else $error("Limit counter not cleared.");
endmodule : pft_limit_timer

// File: rtl/pft_cooldown.sv
// One-second cool-down counter of one channel.
// Assumes start is a single-cycle control and cancel may stay high (OFF and MANUAL modes), both on the same clock.
`timescale 1ns/1ps
module pft_cooldown
  import pft_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  pft_ch_if.cool   ch
);
  typedef struct packed {
    logic [COOL_W-1:0] cnt;
    logic              active;
    logic              done;
  } pft_cool_s;
  pft_cool_s s_r;
  pft_cool_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (ch.cancel)
      s_nxt.active = 1'b0;
    else if (ch.start)
    begin
      s_nxt.active = 1'b1;
      s_nxt.cnt    = '0;
    end
    else if (ch.tick && s_r.active)
    begin
      if (s_r.cnt == COOL_TICKS - 10'h001)
      begin
        s_nxt.active = 1'b0;
        s_nxt.done   = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else if (ch.ce)
      s_r <= s_nxt;
  end

  assign ch.cool_active = s_r.active;
  assign ch.cool_done   = s_r.done;

  AST_COOL_CANCEL: assert property (@(posedge clk) disable iff (!reset_n)
    ch.ce && ch.cancel |=> !s_r.active && !s_r.done)
    else $error("Cool-down not cancelled.");
  AST_COOL_START: assert property (@(posedge clk) disable iff (!reset_n)
    ch.ce && ch.start && !ch.cancel |=> s_r.active && s_r.cnt == '0)
    else $error("Cool-down did not start.");
endmodule : pft_cooldown

// File: rtl/pft_top.sv
// Port fault timers: limit and inrush timing with cool-down per channel.
// Assumes a register port on the same clock and pins for sense and shutdown.
`timescale 1ns/1ps
module pft_top
  import pft_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           clk_en,
  input  wire logic [3:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  output logic                irq,
  input  wire logic [NCH-1:0] turn_on_req,
  input  wire logic [NCH-1:0] power_off_cmd,
  input  wire logic [NCH-1:0] reset_cmd,
  input  wire logic [NCH-1:0] dc_disconnect,
  input  wire logic           fast_shutdown_in,
  input  wire logic [NCH-1:0] current_limit,
  input  wire logic [NCH-1:0] inrush_limit,
  output logic      [NCH-1:0] port_power_en,
  output logic      [NCH-1:0] detect_start
);
  typedef struct packed {
    logic [7:0]                      timing;
    logic [NCH-1:0]                  fb_en;
    logic [NCH-1:0]                  oss_sel;
    pft_mode_e                       mode;
    logic [NCH-1:0]                  det_en;
    logic [NCH-1:0]                  cls_en;
    logic [2*NCH-1:0]                irq_stat;
    logic [2*NCH-1:0]                irq_en;
    logic [7:0]                      rdata;
    logic                            irq;
    logic [NCH-1:0]                  power;
    logic [NCH-1:0]                  inr_run;
    logic [NCH-1:0]                  cause_inr;
    logic [NCH-1:0]                  det_start;
    logic [NCH-1:0][INR_W-1:0]       inr_cnt;
    logic [NCH-1:0][1:0]             inr_sel;
    logic [31:0]                     tick_cnt;
    logic                            tick;
    logic                            fs_s1;
    logic                            fs_s2;
    logic [NCH-1:0]                  lim_s1;
    logic [NCH-1:0]                  lim_s2;
    logic [NCH-1:0]                  inr_s1;
    logic [NCH-1:0]                  inr_s2;
  } pft_top_s;

  pft_top_s       s_r;
  pft_top_s       s_nxt;
  logic [NCH-1:0] lim_fault;
  logic [NCH-1:0] cool_act;
  logic [NCH-1:0] cool_done;
  logic [NCH-1:0] cool_start;
  logic [NCH-1:0] cool_cancel;
  logic [NCH-1:0] lim_clear;
  logic           lim_restart;
  logic [NCH-1:0] inr_fault;
  logic [NCH-1:0] off_now;

  pft_ch_if ch[NCH] ();

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    assign ch[g].ce       = clk_en;
    assign ch[g].tick     = s_r.tick;
    assign ch[g].limiting = s_r.lim_s2[g];
    assign ch[g].armed    = s_r.power[g] && !s_r.inr_run[g];
    assign ch[g].clear    = lim_clear[g];
    assign ch[g].restart  = lim_restart;
    assign ch[g].limit_to = pft_lim_timeout(s_r.fb_en[g],
                              s_r.timing[LIM_SEL_LSB +: 2]);
    assign ch[g].start    = cool_start[g];
    assign ch[g].cancel   = cool_cancel[g];
    assign lim_fault[g]   = ch[g].limit_fault;
    assign cool_act[g]    = ch[g].cool_active;
    assign cool_done[g]   = ch[g].cool_done;

    pft_limit_timer u_lim (
      .clk     (clk),
      .reset_n (reset_n),
      .ch      (ch[g])
    );

    pft_cooldown u_cool (
      .clk     (clk),
      .reset_n (reset_n),
      .ch      (ch[g])
    );
  end

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.rdata   = 8'h00;
    s_nxt.det_start = '0;
    s_nxt.tick    = 1'b0;
    cool_start    = '0;
    cool_cancel   = '0;
    lim_clear     = '0;
    lim_restart   = 1'b0;
    inr_fault     = '0;
    off_now       = '0;

    // Sense and fast-shutdown pins pass two flip-flops before use.
    s_nxt.fs_s1  = fast_shutdown_in;
    s_nxt.fs_s2  = s_r.fs_s1;
    s_nxt.lim_s1 = current_limit;
    s_nxt.lim_s2 = s_r.lim_s1;
    s_nxt.inr_s1 = inrush_limit;
    s_nxt.inr_s2 = s_r.inr_s1;

    // Millisecond tick.
    if (s_r.tick_cnt >= 32'(TICK_LEN - 1))
    begin
      s_nxt.tick_cnt = 32'h0000_0000;
      s_nxt.tick     = 1'b1;
    end
    else
      s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;

    // Register writes.
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_TIMING:
        begin
          s_nxt.timing = reg_wdata;
          lim_restart  = reg_wdata[LIM_SEL_LSB +: 2] !=
                         s_r.timing[LIM_SEL_LSB +: 2];
        end
        ADDR_FOLDBACK:
        begin
          s_nxt.fb_en   = reg_wdata[NCH-1:0];
          s_nxt.oss_sel = reg_wdata[OSS_SEL_LSB +: NCH];
        end
        ADDR_MODE:     s_nxt.mode = pft_mode_e'(reg_wdata[1:0]);
        ADDR_DETCLS:
        begin
          s_nxt.det_en = reg_wdata[NCH-1:0];
          s_nxt.cls_en = reg_wdata[NCH +: NCH];
        end
        ADDR_IRQ_CLR:  s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata;
        ADDR_IRQ_EN:   s_nxt.irq_en = reg_wdata;
        default:       s_nxt.irq_en = s_r.irq_en;
      endcase
    end

    // Per-channel sequencing.
    for (int i = 0; i < NCH; i++)
    begin
      off_now[i] = power_off_cmd[i] || reset_cmd[i] || dc_disconnect[i]
                   || (s_r.fs_s2 && s_r.oss_sel[i]);
      lim_clear[i] = off_now[i];
      cool_cancel[i] = reset_cmd[i] || s_nxt.mode == MODE_OFF
                       || s_nxt.mode == MODE_MANUAL;

      if (s_r.inr_run[i] && s_r.tick)
      begin
        if (s_r.inr_cnt[i] + 8'h01 >= pft_inr_ticks(s_r.inr_sel[i]))
        begin
          s_nxt.inr_run[i] = 1'b0;
          inr_fault[i]     = s_r.inr_s2[i];
        end
        else
          s_nxt.inr_cnt[i] = s_r.inr_cnt[i] + 8'h01;
      end

      if (off_now[i])
      begin
        s_nxt.power[i]   = 1'b0;
        s_nxt.inr_run[i] = 1'b0;
      end
      else if (lim_fault[i] || inr_fault[i])
      begin
        s_nxt.power[i]     = 1'b0;
        s_nxt.inr_run[i]   = 1'b0;
        s_nxt.cause_inr[i] = inr_fault[i];
        cool_start[i]      = 1'b1;
      end
      else if (turn_on_req[i] && !cool_act[i] && !s_r.power[i])
      begin
        s_nxt.power[i]   = 1'b1;
        s_nxt.inr_run[i] = 1'b1;
        s_nxt.inr_cnt[i] = '0;
        s_nxt.inr_sel[i] = s_r.timing[INR_SEL_LSB +: 2];
      end

      if (cool_done[i] && s_r.mode == MODE_SEMIAUTO)
        s_nxt.det_start[i] = s_r.cause_inr[i]
          ? (s_r.det_en[i] && s_r.cls_en[i])
          : s_r.det_en[i];

      // Hardware sets win over a clear in the same cycle.
      if (lim_fault[i] && !off_now[i])
        s_nxt.irq_stat[i] = 1'b1;
      if (inr_fault[i] && !off_now[i])
        s_nxt.irq_stat[NCH+i] = 1'b1;
    end

    // Register reads, data stands one cycle.
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_TIMING:   s_nxt.rdata = s_r.timing;
        ADDR_FOLDBACK: s_nxt.rdata = {s_r.oss_sel, s_r.fb_en};
        ADDR_MODE:     s_nxt.rdata = {6'h00, s_r.mode};
        ADDR_DETCLS:   s_nxt.rdata = {s_r.cls_en, s_r.det_en};
        ADDR_STATUS:   s_nxt.rdata = {cool_act, s_r.power};
        ADDR_IRQ_STAT: s_nxt.rdata = s_r.irq_stat;
        ADDR_IRQ_EN:   s_nxt.rdata = s_r.irq_en;
        default:       s_nxt.rdata = 8'h00;
      endcase
    end

    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign reg_rdata     = s_r.rdata;
  assign irq           = s_r.irq;
  assign port_power_en = s_r.power;
  assign detect_start  = s_r.det_start;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_inr_end;
    clk_en && s_r.inr_run[0] && s_r.tick && s_r.inr_s2[0]
    && s_r.inr_cnt[0] + 8'h01 >= pft_inr_ticks(s_r.inr_sel[0])
    && !off_now[0] && !cool_cancel[0];
  endsequence

  sequence seq_cool_end_semi;
    clk_en && cool_done[0] && s_r.mode == MODE_SEMIAUTO;
  endsequence

  AST_NOMINAL_TO: assert property (
    !s_r.fb_en[0] |-> ch[0].limit_to ==
      LIM_W'(LIM_NOM_MS * UP_RATIO * 1000 / TICK_US))
    else $error("Nominal limit timeout not used.");
  AST_FB_MAP: assert property (
    s_r.fb_en[0] && s_r.timing[7:6] == 2'h3 |->
      ch[0].limit_to == LIM_W'(LIM_MS_3 * UP_RATIO))
    else $error("Foldback code 3 timeout wrong.");
  AST_COOL_BLOCKS_ON: assert property (
    clk_en && turn_on_req[0] && cool_act[0] && !s_r.power[0]
    |=> !port_power_en[0])
    else $error("Turn-on accepted during cool-down.");
  AST_INR_OFF: assert property (
    seq_inr_end |=> !port_power_en[0] && cool_act[0])
    else $error("Inrush timeout did not power off.");
  AST_SEMI_DET: assert property (
    seq_cool_end_semi and s_r.det_en[0] && !s_r.cause_inr[0]
    |=> detect_start[0])
    else $error("No detection after limit cool-down.");
  AST_SEMI_CLS: assert property (
    seq_cool_end_semi and s_r.cause_inr[0] && !s_r.cls_en[0]
    |=> !detect_start[0])
    else $error("Detection without class enable.");
  AST_CANCEL: assert property (
    clk_en && reset_cmd[0] |=> ##1 !cool_act[0])
    else $error("Reset command did not cancel cool-down.");
  AST_LIM_FIELD: assert property (
    clk_en && reg_wr && reg_addr == ADDR_TIMING |=>
      s_r.timing[7:6] == $past(reg_wdata[7:6]))
    else $error("Limit select not stored.");
  AST_INR_FIELD: assert property (
    clk_en && reg_wr && reg_addr == ADDR_TIMING |=>
      s_r.timing[5:4] == $past(reg_wdata[5:4]))
    else $error("Inrush select not stored.");
  AST_INR_LATCH: assert property (
    clk_en && s_r.inr_run[0] && !turn_on_req[0]
    |=> s_r.inr_sel[0] == $past(s_r.inr_sel[0]))
    else $error("Inrush select changed mid-run.");
  AST_RESTART: assert property (
    clk_en && lim_restart && s_r.power[0] |=> !lim_fault[0])
    else $error("Limit timer not restarted.");
  AST_OFF_CLEAR: assert property (
    clk_en && off_now[0] |=> !port_power_en[0])
    else $error("Turn-off command ignored.");
endmodule : pft_top

// File: tb/pft_port_model.sv
// Behavioural power stage and current sense of the four ports.
// Assumes the bench sets the force masks right after a clock edge.
`timescale 1ns/1ps
module pft_port_model
  import pft_pkg::*;
(
  input  wire logic [NCH-1:0] port_power_en,
  input  wire logic [NCH-1:0] lim_force,
  input  wire logic [NCH-1:0] inr_force,
  output logic      [NCH-1:0] current_limit,
  output logic      [NCH-1:0] inrush_limit
);
  // An unpowered port draws no current, so no limit can be active.
  assign current_limit = port_power_en & lim_force;
  assign inrush_limit  = port_power_en & inr_force;
endmodule : pft_port_model

// File: tb/pft_top_tb.sv
// Self-checking bench of the port fault timers.
// Assumes a short tick of four clocks and a behavioural port model.
`timescale 1ns/1ps
module pft_top_tb;
  import pft_pkg::*;
  localparam int T = 4;
  logic           clk;
  logic           reset_n;
  logic           clk_en;
  logic [3:0]     reg_addr;
  logic [7:0]     reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  logic [7:0]     reg_rdata;
  logic           irq;
  logic [NCH-1:0] turn_on_req;
  logic [NCH-1:0] power_off_cmd;
  logic [NCH-1:0] reset_cmd;
  logic [NCH-1:0] dc_disconnect;
  logic           fast_shutdown_in;
  logic [NCH-1:0] current_limit;
  logic [NCH-1:0] inrush_limit;
  logic [NCH-1:0] port_power_en;
  logic [NCH-1:0] detect_start;
  logic [NCH-1:0] lim_force;
  logic [NCH-1:0] inr_force;
  logic [7:0]     d;
  logic           ok;
  int             err_total;
  int             check_count;
  int             cyc;
  int             lim_ms [4] = '{58, 15, 10, 6};

  pft_top #(.TICK_LEN(T)) pft_top_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .turn_on_req(turn_on_req),
    .power_off_cmd(power_off_cmd), .reset_cmd(reset_cmd),
    .dc_disconnect(dc_disconnect), .fast_shutdown_in(fast_shutdown_in),
    .current_limit(current_limit), .inrush_limit(inrush_limit),
    .port_power_en(port_power_en), .detect_start(detect_start));

  pft_port_model pft_port_model_inst (
    .port_power_en(port_power_en), .lim_force(lim_force),
    .inr_force(inr_force), .current_limit(current_limit),
    .inrush_limit(inrush_limit));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic on0;
    @(posedge clk);
    turn_on_req <= 4'h1;
    @(posedge clk);
    turn_on_req <= 4'h0;
  endtask : on0

  // Waits for port 0 to drop and tells whether it fell inside lo..hi.
  task automatic wait_off(input int lo, input int hi, output logic r);
    int n;
    // Skips the launching edge, whose new power state is not yet visible.
    @(posedge clk);
    n = 1;
    while (port_power_en[0] === 1'b1 && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    r = (n >= lo) && (port_power_en[0] === 1'b0);
  endtask : wait_off

  // Waits for the detection start pulse of port 0.
  task automatic wait_det(output logic r);
    int n;
    n = 0;
    r = 1'b0;
    while (!r && n < 1010 * T)
    begin
      @(posedge clk);
      r = (detect_start[0] === 1'b1);
      n++;
    end
  endtask : wait_det

  initial
  begin
    err_total = 0;
    check_count = 0;
    cyc = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    turn_on_req = 4'h0;
    power_off_cmd = 4'h0;
    reset_cmd = 4'h0;
    dc_disconnect = 4'h0;
    fast_shutdown_in = 1'b0;
    lim_force = 4'h0;
    inr_force = 4'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_TIMING, d);
    chk(d, 8'h00);
    rd(4'h8, d);
    chk(d, 8'h00);
    wr(ADDR_TIMING, 8'hD0);
    rd(ADDR_TIMING, d);
    chk(d, 8'hD0);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_DETCLS, 8'h11);
    wr(ADDR_IRQ_EN, 8'hFF);
    // Inrush fault, refused turn-on, then detection after cool-down.
    inr_force <= 4'h1;
    on0();
    wait_off(29 * T, 33 * T + 8, ok);
    chk(8'(ok), 8'h01);
    inr_force <= 4'h0;
    repeat (3) @(posedge clk);
    chk(8'(irq), 8'h01);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h10);
    rd(ADDR_STATUS, d);
    chk(d, 8'h10);
    on0();
    repeat (3) @(posedge clk);
    chk(8'(port_power_en), 8'h00);
    wr(ADDR_IRQ_CLR, 8'hFF);
    wait_det(ok);
    chk(8'(ok), 8'h01);
    chk(8'(irq), 8'h00);
    // Nominal limit timeout, counted only after the inrush window.
    lim_force <= 4'h1;
    on0();
    wait_off(89 * T, 93 * T + 8, ok);
    chk(8'(ok), 8'h01);
    repeat (3) @(posedge clk);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h01);
    on0();
    repeat (3) @(posedge clk);
    chk(8'(port_power_en), 8'h00);
    wr(ADDR_IRQ_CLR, 8'hFF);
    wait_det(ok);
    chk(8'(ok), 8'h01);
    // Foldback codes, each cool-down cut short by a reset command.
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_FOLDBACK, 8'h01);
      wr(ADDR_TIMING, {2'(c), 6'h10});
      on0();
      wait_off((29 + lim_ms[c]) * T, (33 + lim_ms[c]) * T + 8, ok);
      chk(8'(ok), 8'h01);
      @(posedge clk);
      reset_cmd <= 4'h1;
      @(posedge clk);
      reset_cmd <= 4'h0;
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS, d);
      chk(d, 8'h00);
    end
    // Limit select rewritten mid-count restarts the timer at 58 ms.
    on0();
    repeat (33 * T) @(posedge clk);
    wr(ADDR_TIMING, 8'h10);
    wait_off(57 * T, 59 * T + 8, ok);
    chk(8'(ok), 8'h01);
    @(posedge clk);
    reset_cmd <= 4'h1;
    @(posedge clk);
    reset_cmd <= 4'h0;
    // Inrush select rewritten mid-window waits for the next turn-on.
    inr_force <= 4'h1;
    on0();
    wr(ADDR_TIMING, 8'h30);
    wait_off(28 * T, 31 * T + 8, ok);
    chk(8'(ok), 8'h01);
    inr_force <= 4'h0;
    // Without class enable, no detection follows an inrush cool-down.
    wr(ADDR_DETCLS, 8'h01);
    wait_det(ok);
    chk(8'(ok), 8'h00);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    // Fast shutdown turns a selected port off.
    wr(ADDR_FOLDBACK, 8'h11);
    on0();
    repeat (4) @(posedge clk);
    chk(8'(port_power_en), 8'h01);
    fast_shutdown_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'(port_power_en), 8'h00);
    fast_shutdown_in <= 1'b0;
    print_verdict();
  end
endmodule : pft_top_tb
